// File: shared/baa_pkg.sv
/*
 Package for the byte add and logic execution block: opcode fields,
 quarter-cycle states, status flag layout and the decoded operation struct.
 Assumes a 16-bit instruction word and an 8-bit data path.
*/
package baa_pkg;
   // ***************************************************
   // Instruction fields
   // ***************************************************
   localparam int INSN_W = 16;
   localparam int DATA_W = 8;
   localparam logic [5:0] OPC_ADDFC = 6'h08; // 0010 00
   localparam logic [5:0] OPC_ADDF = 6'h09;  // 0010 01
   localparam logic [7:0] OPC_ANDL = 8'h0B;  // 0000 1011
   localparam logic [7:0] OPC_ADDL = 8'h0F;  // 0000 1111
   localparam int BIT_D = 9;
   localparam int BIT_A = 8;
   localparam logic [7:0] IDX_MAX = 8'h5F;
   // ***************************************************
   // Status flag positions
   // ***************************************************
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   localparam logic [4:0] FLG_RST = 5'h00;
   localparam logic [7:0] W_RST = 8'h00;

   typedef enum logic [1:0] {
      BAA_Q1 = 2'b00,
      BAA_Q2 = 2'b01,
      BAA_Q3 = 2'b11,
      BAA_Q4 = 2'b10
   } baa_q_e;

   typedef enum logic [2:0] {
      BAA_OP_NONE = 3'h0,
      BAA_OP_ADDL = 3'h1,
      BAA_OP_ADDF = 3'h2,
      BAA_OP_ADDFC = 3'h3,
      BAA_OP_ANDL = 3'h4
   } baa_op_e;

   typedef struct packed {
      baa_op_e op;
      logic to_file;
      logic use_bank;
      logic indexed;
      logic [7:0] operand;
   } baa_dec_s;

   typedef struct packed {
      logic we;
      logic use_bank;
      logic indexed;
      logic [7:0] addr;
      logic [7:0] data;
   } baa_wr_s;
endpackage

// File: tb/baa_core_tb_top.sv
/*
 Self-checking bench for the byte add and logic execution core.
 Assumes the core captures a word on each Q1 edge and answers four edges on.
*/
`timescale 1ns/1ns
module baa_core_tb_top;
   import baa_pkg::*;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
   err_count++; \
   $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] insn = 16'h0000;
   logic ext_set_en = 1'b0;
   logic [7:0] file_rdata = 8'h00;
   logic [1:0] quarter;
   logic file_re, file_rd_bank, file_rd_indexed;
   logic [7:0] file_raddr, w_out;
   baa_wr_s file_wr;
   logic [4:0] status_out;
   int err_count = 0;
   int n_compared = 0;
   logic [7:0] w_m = W_RST;
   logic [4:0] st_m = FLG_RST;

   baa_core dut (.ref_clk(ref_clk), .srst(srst), .insn(insn),
      .ext_set_en(ext_set_en), .file_rdata(file_rdata), .quarter(quarter),
      .file_re(file_re), .file_raddr(file_raddr), .file_rd_bank(file_rd_bank),
      .file_rd_indexed(file_rd_indexed), .file_wr(file_wr), .w_out(w_out),
      .status_out(status_out));

   always #5 ref_clk = ~ref_clk;

   // ***************************************************
   // Reference arithmetic and the shared instruction driver
   // ***************************************************
   function automatic void add8(input logic [7:0] a, input logic [7:0] b,
      input logic ci, output logic [7:0] r, output logic [4:0] f);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      r = s[7:0];
      f = FLG_RST;
      f[FLG_C] = s[8];
      f[FLG_DC] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci}) > 5'h0F;
      f[FLG_Z] = (r == 8'h00);
      f[FLG_OV] = (a[7] == b[7]) && (r[7] != a[7]);
      f[FLG_N] = r[7];
   endfunction

   // A no-op word follows each instruction, so a held word is never rerun.
   task automatic exec(input logic [15:0] ins, input logic ext,
      input logic [7:0] rd);
      logic [7:0] r;
      logic [4:0] f;
      logic fop, d, idx;
      int n;
      n = 0;
      while (quarter !== BAA_Q1 && n < 8) begin
         @(negedge ref_clk);
         n++;
      end
      fop = (ins[15:11] == 5'b00100);
      d = ins[BIT_D];
      idx = ext && !ins[BIT_A] && (ins[7:0] <= IDX_MAX);
      r = w_m;
      f = st_m;
      if (ins[15:8] == OPC_ADDL) add8(w_m, ins[7:0], 1'b0, r, f);
      else if (ins[15:8] == OPC_ANDL) begin
         r = w_m & ins[7:0];
         f[FLG_N] = r[7];
         f[FLG_Z] = (r == 8'h00);
      end
      else if (fop)
         add8(w_m, rd, (ins[15:10] == OPC_ADDFC) & st_m[FLG_C], r, f);
      insn = ins;
      ext_set_en = ext;
      file_rdata = rd;
      @(negedge ref_clk);
      `CHK(quarter, 2'b01)
      `CHK(file_re, fop)
      if (fop) begin
         `CHK(file_raddr, ins[7:0])
         `CHK(file_rd_bank, ins[BIT_A])
         `CHK(file_rd_indexed, idx)
      end
      insn = 16'h0000;
      @(negedge ref_clk);
      file_rdata = ~rd;
      @(negedge ref_clk);
      `CHK(w_out, w_m)
      @(negedge ref_clk);
      `CHK(file_wr.we, fop && d)
      if (fop && d) begin
         `CHK(file_wr.addr, ins[7:0])
         `CHK(file_wr.data, r)
         `CHK(file_wr.use_bank, ins[BIT_A])
         `CHK(file_wr.indexed, idx)
      end
      else w_m = r;
      st_m = f;
      `CHK(w_out, w_m)
      `CHK(status_out, st_m)
   endtask

   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_add_literal();
      logic [7:0] k[4] = '{8'h10, 8'h15, 8'h7F, 8'h5C};
      foreach (k[i]) exec({OPC_ADDL, k[i]}, 1'b0, 8'h00);
   endtask

   task automatic t_and_literal();
      exec({OPC_ANDL, 8'hFF}, 1'b0, 8'h00);
      exec({OPC_ADDFC, 2'b00, 8'h21}, 1'b0, 8'h9F);
      exec({OPC_ANDL, 8'h80}, 1'b0, 8'h00);
   endtask

   task automatic t_add_file();
      logic [15:0] w[6] = '{{OPC_ADDF, 2'b10, 8'h5F},
         {OPC_ADDF, 2'b10, 8'h60}, {OPC_ADDF, 2'b01, 8'h5F},
         {OPC_ADDF, 2'b10, 8'h10}, {OPC_ADDFC, 2'b11, 8'hC2},
         {OPC_ADDFC, 2'b00, 8'h4D}};
      logic [7:0] rd[6] = '{8'hC2, 8'h80, 8'h01, 8'hFF, 8'h4D, 8'h33};
      logic [5:0] ex = 6'b101111;
      foreach (w[i]) exec(w[i], ex[i], rd[i]);
   endtask

   task automatic t_refuse_and_reset();
      exec(16'hFFFF, 1'b1, 8'h5A);
      srst = 1'b1;
      repeat (2) @(negedge ref_clk);
      srst = 1'b0;
      `CHK(w_out, W_RST)
      `CHK(status_out, FLG_RST)
      `CHK(quarter, BAA_Q1)
      w_m = W_RST;
      st_m = FLG_RST;
      exec({OPC_ADDL, 8'h01}, 1'b0, 8'h00);
   endtask

   // ***************************************************
   // Run control
   // ***************************************************
   task automatic stop_test();
      $display("err_count=%0d n_compared=%0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end
      else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(negedge ref_clk);
      srst = 1'b0;
      t_add_literal();
      t_and_literal();
      t_add_file();
      t_refuse_and_reset();
      stop_test();
   end

   // Fifteen instructions of four cycles each fit well inside this.
   initial begin
      #20000;
      err_count++;
      stop_test();
   end
endmodule

// File: verilog/baa_core.sv
/*
 Four-quarter execution of add literal, add to file, add with carry and
 AND literal, holding the working register and the status flags.
 Assumes the fetch stage presents a word in Q1 and the data memory returns
 read data combinationally during Q2.
*/
// What this block does
// - Add accumulator to file, sum to destination.
// - Destination bit zero accumulator, one file.
// - Access bit zero access bank, one bank.
// - Extended set, access zero, low address: indexed.
// - Add with carry sums accumulator, carry, file.
// - Add-with-carry opcode 0010 00da.
// - Add-with-carry updates N, OV, C, DC, Z.
// - AND literal into accumulator.
// - AND-literal opcode 0000 1011.
// - AND literal updates only N and Z.
// - Four quarters, destination written in Q4.
// - Add literal updates accumulator and all flags.
`timescale 1ns/1ns
module baa_core (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [baa_pkg::INSN_W-1:0] insn,
   input wire logic ext_set_en,
   input wire logic [7:0] file_rdata,
   output logic [1:0] quarter,
   output logic file_re,
   output logic [7:0] file_raddr,
   output logic file_rd_bank,
   output logic file_rd_indexed,
   output baa_pkg::baa_wr_s file_wr,
   output logic [7:0] w_out,
   output logic [4:0] status_out
);
   import baa_pkg::*;

   // ***************************************************
   // Decode and state
   // ***************************************************
   baa_dec_s dec_now;
   baa_dec_s dec_reg, dec_next;
   baa_q_e q_reg, q_next;
   logic [7:0] opa_reg, opa_next;
   logic [7:0] res_reg, res_next;
   logic [4:0] flg_calc_reg, flg_calc_next;
   logic [7:0] w_reg, w_next;
   logic [4:0] st_reg, st_next;
   baa_wr_s wr_reg, wr_next;
   logic [8:0] sum;
   logic [4:0] nib;
   logic cin;
   logic [7:0] b_op;

   baa_decode u_dec (
      .insn(insn),
      .ext_set_en(ext_set_en),
      .dec(dec_now)
   );

   // ***************************************************
   // Arithmetic
   // ***************************************************
   always_comb begin
      cin = (dec_reg.op == BAA_OP_ADDFC) ? st_reg[FLG_C] : 1'b0;
      b_op = opa_reg;
      sum = {1'b0, w_reg} + {1'b0, b_op} + {8'h00, cin};
      nib = {1'b0, w_reg[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
   end

   always_comb begin
      q_next = q_reg;
      dec_next = dec_reg;
      opa_next = opa_reg;
      res_next = res_reg;
      flg_calc_next = flg_calc_reg;
      w_next = w_reg;
      st_next = st_reg;
      wr_next = '0;
      case (q_reg)
         BAA_Q1: begin
            dec_next = dec_now;
            q_next = BAA_Q2;
         end
         BAA_Q2: begin
            if (dec_reg.op == BAA_OP_ADDF || dec_reg.op == BAA_OP_ADDFC) begin
               opa_next = file_rdata;
            end else begin
               opa_next = dec_reg.operand;
            end
            q_next = BAA_Q3;
         end
         BAA_Q3: begin
            flg_calc_next = st_reg;
            if (dec_reg.op == BAA_OP_ANDL) begin
               res_next = w_reg & opa_reg;
               flg_calc_next[FLG_Z] = ((w_reg & opa_reg) == 8'h00);
               flg_calc_next[FLG_N] = w_reg[7] & opa_reg[7];
            end else begin
               res_next = sum[7:0];
               flg_calc_next[FLG_C] = sum[8];
               flg_calc_next[FLG_DC] = nib[4];
               flg_calc_next[FLG_Z] = (sum[7:0] == 8'h00);
               flg_calc_next[FLG_N] = sum[7];
               flg_calc_next[FLG_OV] = (w_reg[7] == b_op[7]) &&
                                       (sum[7] != w_reg[7]);
            end
            q_next = BAA_Q4;
         end
         BAA_Q4: begin
            if (dec_reg.op != BAA_OP_NONE) begin
               st_next = flg_calc_reg;
               if ((dec_reg.op == BAA_OP_ADDF || dec_reg.op == BAA_OP_ADDFC)
                   && dec_reg.to_file) begin
                  wr_next.we = 1'b1;
                  wr_next.use_bank = dec_reg.use_bank;
                  wr_next.indexed = dec_reg.indexed;
                  wr_next.addr = dec_reg.operand;
                  wr_next.data = res_reg;
               end else begin
                  w_next = res_reg;
               end
            end
            q_next = BAA_Q1;
         end
         default: q_next = BAA_Q1;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q_reg <= BAA_Q1;
         dec_reg <= '0;
         opa_reg <= 8'h00;
         res_reg <= 8'h00;
         flg_calc_reg <= FLG_RST;
         w_reg <= W_RST;
         st_reg <= FLG_RST;
         wr_reg <= '0;
      end else begin
         q_reg <= q_next;
         dec_reg <= dec_next;
         opa_reg <= opa_next;
         res_reg <= res_next;
         flg_calc_reg <= flg_calc_next;
         w_reg <= w_next;
         st_reg <= st_next;
         wr_reg <= wr_next;
      end
   end

   // ***************************************************
   // Outputs
   // ***************************************************
   // The file read is requested in Q2 so the operand is latched that quarter.
   assign quarter = q_reg;
   assign file_re = (q_reg == BAA_Q2) &&
                    (dec_reg.op == BAA_OP_ADDF || dec_reg.op == BAA_OP_ADDFC);
   assign file_raddr = dec_reg.operand;
   assign file_rd_bank = dec_reg.use_bank;
   assign file_rd_indexed = dec_reg.indexed;
   assign file_wr = wr_reg;
   assign w_out = w_reg;
   assign status_out = st_reg;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_q3_to_q4;
      (q_reg == BAA_Q3) ##1 (q_reg == BAA_Q4);
   endsequence

   AST_QUARTER_ORDER: assert property (
      (q_reg == BAA_Q2) |=> s_q3_to_q4 ##1 (q_reg == BAA_Q1))
      else $error("Quarter sequence broken.");
   AST_WRITE_Q4_ONLY: assert property (
      wr_next.we |-> (q_reg == BAA_Q4))
      else $error("File write outside the last quarter.");
   AST_DEST_W: assert property (
      (q_reg == BAA_Q4 && dec_reg.op == BAA_OP_ADDF && !dec_reg.to_file)
      |=> (w_reg == $past(res_reg)) && !wr_reg.we)
      else $error("Destination zero did not load the accumulator.");
   AST_DEST_F: assert property (
      (q_reg == BAA_Q4 && dec_reg.op == BAA_OP_ADDFC && dec_reg.to_file)
      |=> wr_reg.we && $stable(w_reg))
      else $error("Destination one did not write the file.");
   AST_ANDL_RESULT: assert property (
      (q_reg == BAA_Q3 && dec_reg.op == BAA_OP_ANDL)
      |=> ##1 (w_reg == ($past(w_reg, 2) & $past(opa_reg, 2))))
      else $error("AND literal result wrong.");
   AST_ANDL_KEEP: assert property (
      (q_reg == BAA_Q4 && dec_reg.op == BAA_OP_ANDL)
      |=> (st_reg[FLG_C] == $past(st_reg[FLG_C])) &&
          (st_reg[FLG_DC] == $past(st_reg[FLG_DC])) &&
          (st_reg[FLG_OV] == $past(st_reg[FLG_OV])))
      else $error("AND literal changed an arithmetic flag.");
   AST_ADDL_SUM: assert property (
      (q_reg == BAA_Q3 && dec_reg.op == BAA_OP_ADDL)
      |=> ##1 (w_reg == 8'($past(w_reg, 2) + $past(opa_reg, 2))))
      else $error("Add literal sum wrong.");
   AST_CARRY_IN: assert property (
      (q_reg == BAA_Q3 && dec_reg.op == BAA_OP_ADDFC)
      |=> (res_reg == 8'($past(w_reg) + $past(opa_reg) +
                         8'($past(st_reg[FLG_C])))))
      else $error("Add with carry ignored the carry.");
   AST_INDEXED: assert property (
      (q_reg == BAA_Q2 && dec_reg.indexed)
      |-> !dec_reg.use_bank && (dec_reg.operand <= IDX_MAX))
      else $error("Indexed mode outside its range.");
   AST_ADDF_SUM: assert property (
      (q_reg == BAA_Q3 && dec_reg.op == BAA_OP_ADDF)
      |=> (res_reg == 8'($past(w_reg) + $past(opa_reg))))
      else $error("Add to file sum wrong.");
   AST_ANDL_FLAGS: assert property (
      (q_reg == BAA_Q3 && dec_reg.op == BAA_OP_ANDL)
      |=> ##1 ((st_reg[FLG_Z] == (w_reg == 8'h00)) &&
               (st_reg[FLG_N] == w_reg[7])))
      else $error("AND literal zero or negative flag wrong.");
   // A held strobe would write the same file byte twice.
   AST_WRITE_PULSE: assert property (
      wr_reg.we |=> !wr_reg.we)
      else $error("File write strobe held longer than one cycle.");
endmodule

// File: verilog/baa_decode.sv
/*
 Combinational decoder for the four supported instructions.
 Assumes the instruction word is stable at the Q1 edge, where the core registers the decode.
*/
`timescale 1ns/1ns
module baa_decode (
   input wire logic [baa_pkg::INSN_W-1:0] insn,
   input wire logic ext_set_en,
   output baa_pkg::baa_dec_s dec
);
   import baa_pkg::*;

   always_comb begin
      dec = '0;
      dec.op = BAA_OP_NONE;
      dec.operand = insn[7:0];
      if (insn[15:8] == OPC_ADDL) begin
         dec.op = BAA_OP_ADDL;
      end else if (insn[15:8] == OPC_ANDL) begin
         dec.op = BAA_OP_ANDL;
      end else if (insn[15:10] == OPC_ADDF ||
                   insn[15:10] == OPC_ADDFC) begin
         dec.op = (insn[15:10] == OPC_ADDF) ? BAA_OP_ADDF : BAA_OP_ADDFC;
         dec.to_file = insn[BIT_D];
         dec.use_bank = insn[BIT_A];
         dec.indexed = ext_set_en && !insn[BIT_A] &&
                       (insn[7:0] <= IDX_MAX);
      end
   end
endmodule
